// ---- logic/fan_ctrl_map.vh ----
// named constants for the fan speed and hall control block
`ifndef FAN_CTRL_MAP_VH
`define FAN_CTRL_MAP_VH

// ****************************************************
// clock and analog figures, in their own units
// ****************************************************
`define CLK_MHZ        100
`define TRI_CUR_NA     64500
`define TRI_AMP_MV     1530
`define TRI_CAP_PF     390
`define SST_CUR_NA     4000
`define SST_AMP_MV     1000
`define SST_CAP_PF     1800
`define LOCK_TIME_MS   500

// ****************************************************
// duty scale (per-mille) and command conversion
// ****************************************************
`define DUTY_FULL      11'h3e8
`define DC_SLOPE       97
`define DC_OFFS_MV     88000
`define DC_DIV         300
`define DC_MIN_MV      13'h3e8
`define DC_MAX_MV      13'hfa0
`define WORK_LO        11'h01e
`define WORK_HI        11'h244
`define HALL_HYS_MV    10

// ****************************************************
// selector codes and register offsets
// ****************************************************
`define FG_DIV1        2'h0
`define FG_DIV2        2'h1
`define FG_DIV3        2'h2
`define REG_TRI_HALF   4'h0
`define REG_STATUS     4'h1
`define REG_DUTY       4'h2

`endif

// ---- logic/tri_ramp.v ----
// up/down counter that stands in for a capacitor triangle oscillator
`timescale 1ns/1ps
`include "fan_ctrl_map.vh"

module tri_ramp #(
	parameter W = 16
) (
	// clock and reset
	input  wire         ref_clk,
	input  wire         arst_n,
	// turning point of the ramp
	input  wire [W-1:0] half_count,
	// ramp value and end of each full period
	output reg  [W-1:0] ramp_q,
	output reg          period_end_q
);

	reg dir_down_q;    // high while the ramp falls

	// ****************************************************
	// counter: climbs to half_count, falls back to zero
	// ****************************************************
	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			ramp_q       <= {W{1'b0}};
			dir_down_q   <= 1'b0;
			period_end_q <= 1'b0;
		end else begin
			period_end_q <= 1'b0;
			if (!dir_down_q) begin
				// a shrunk turning point must not strand the ramp above it
				if (ramp_q >= half_count)
					dir_down_q <= 1'b1;
				else
					ramp_q <= ramp_q + {{(W-1){1'b0}}, 1'b1};
			end else begin
				if (ramp_q == {W{1'b0}}) begin
					dir_down_q   <= 1'b0;
					period_end_q <= 1'b1;
				end else
					ramp_q <= ramp_q - {{(W-1){1'b0}}, 1'b1};
			end
		end
	end

endmodule // tri_ramp

// ---- logic/hall_hysteresis.v ----
// hysteresis comparator on the sampled differential hall input
`timescale 1ns/1ps
`include "fan_ctrl_map.vh"

module hall_hysteresis (
	// clock and reset
	input  wire        ref_clk,
	input  wire        arst_n,
	// hall samples in millivolts, same clock domain
	input  wire [11:0] hall_plus,
	input  wire [11:0] hall_minus,
	// comparator level and one-cycle edge marker
	output reg         hall_level_q,
	output reg         hall_edge_q
);

	localparam signed [12:0] HALF_HYS = `HALL_HYS_MV / 2;

	wire signed [12:0] diff;   // plus minus minus, one extra bit
	assign diff = $signed({1'b0, hall_plus}) - $signed({1'b0, hall_minus});

	// ****************************************************
	// switch only past half the window each side
	// ****************************************************
	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			hall_level_q <= 1'b0;
			hall_edge_q  <= 1'b0;
		end else begin
			hall_edge_q <= 1'b0;
			if (!hall_level_q && diff > HALF_HYS) begin
				hall_level_q <= 1'b1;
				hall_edge_q  <= 1'b1;
			end else if (hall_level_q && diff < -HALF_HYS) begin
				hall_level_q <= 1'b0;
				hall_edge_q  <= 1'b1;
			end
		end
	end

endmodule // hall_hysteresis

// ---- logic/fan_speed_ctrl.v ----
// speed command, soft start, hall pulse and phase logic of the fan driver
//
// What this block does
// - PWM mode: output level follows command duty
// - DC mode: command compared against triangle ramp
// - DC mode PWM frequency equals ramp frequency
// - duty rises linearly over working command range
// - hall hysteresis comparator; each edge is event
// - one pulse cycle per 1/2/3 hall cycles
// - selector low: drive phase corrected automatically
// - selector high: drive phase held at zero
// - no speed pulses during start-up mode
// - soft-start timing from slow triangle ramp
// - soft-start duty grows until commanded duty reached
// - DC command converted to equivalent input duty
// - lock detection runs through soft start too
`timescale 1ns/1ps
`include "fan_ctrl_map.vh"

module fan_speed_ctrl #(
	parameter SST_W       = 24,
	parameter SST_HALF    = `SST_CAP_PF * `SST_AMP_MV * `CLK_MHZ
	                        / `SST_CUR_NA,
	parameter LOCK_W      = 26,
	parameter LOCK_CYCLES = `LOCK_TIME_MS * 1000 * `CLK_MHZ,
	parameter SS_STEP     = 1
) (
	// clock and reset
	input  wire        ref_clk,
	input  wire        arst_n,
	// speed command
	input  wire        speed_command_input,
	input  wire [12:0] speed_command_level_mv,
	input  wire        tri_cap_tied_ref,
	input  wire        soft_start_ramp_cap_tied,
	// hall samples
	input  wire [11:0] hall_plus,
	input  wire [11:0] hall_minus,
	// mode pins
	input  wire [1:0]  pulse_divide_select,
	input  wire        phase_shift_select,
	input  wire        conduction_ref,
	input  wire        sleep_req,
	// register port
	input  wire [3:0]  reg_addr,
	input  wire [15:0] reg_wdata,
	input  wire        reg_wr,
	input  wire        reg_rd,
	output reg  [15:0] reg_rdata_q,
	// drive and status
	output reg         drive_pwm_q,
	output reg         speed_pulse_out_q,
	output reg  [15:0] phase_advance_q,
	output reg         lock_fault_q,
	output reg         startup_q
);

	localparam [15:0] TRI_HALF_DEF = `TRI_CAP_PF * `TRI_AMP_MV * `CLK_MHZ
	                                 / `TRI_CUR_NA;
	localparam [SST_W-1:0]  SST_HALF_C = SST_HALF;
	localparam [LOCK_W-1:0] LOCK_C     = LOCK_CYCLES - 1;
	localparam [10:0]       STEP_C     = SS_STEP;
	localparam [3:0] ST_SLEEP = 4'h1;
	localparam [3:0] ST_START = 4'h2;
	localparam [3:0] ST_RUN   = 4'h4;
	localparam [3:0] ST_LOCK  = 4'h8;

	// ****************************************************
	// pin synchronisers, two flops per bit
	// ****************************************************
	wire [7:0] pin_raw;   // asynchronous pins gathered
	reg  [7:0] pin_s1_q;  // first stage, read only by second
	reg  [7:0] pin_s2_q;  // safe copy
	assign pin_raw = {pulse_divide_select, conduction_ref, sleep_req,
	                  phase_shift_select, soft_start_ramp_cap_tied,
	                  tri_cap_tied_ref, speed_command_input};
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi = gi + 1) begin : g_sync
			// same two-stage flop for every pin
			always @(posedge ref_clk or negedge arst_n) begin
				if (!arst_n) begin
					pin_s1_q[gi] <= 1'b0;
					pin_s2_q[gi] <= 1'b0;
				end else begin
					pin_s1_q[gi] <= pin_raw[gi];
					pin_s2_q[gi] <= pin_s1_q[gi];
				end
			end
		end
	endgenerate
	wire       vsp_s    = pin_s2_q[0];
	wire       pwm_mode = pin_s2_q[1];
	wire       ss_bypass = pin_s2_q[2];
	wire       ps_fixed = pin_s2_q[3];
	wire       sleep_s  = pin_s2_q[4];
	wire       cond_s   = pin_s2_q[5];
	wire [1:0] fg_sel   = pin_s2_q[7:6];

	// ****************************************************
	// register port
	// ****************************************************
	reg  [15:0] tri_half_q;  // pwm ramp turning point, software set
	reg  [3:0]  state_q;
	reg  [10:0] applied_q;   // duty in use, per-mille
	reg  [10:0] target_q;    // commanded duty after scaling
	// write decode; only the ramp turning point is writable
	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n)
			tri_half_q <= TRI_HALF_DEF;
		else if (reg_wr && reg_addr == `REG_TRI_HALF)
			tri_half_q <= reg_wdata;
	end
	// read data stands the cycle after the strobe only
	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n)
			reg_rdata_q <= 16'h0000;
		else if (!reg_rd)
			reg_rdata_q <= 16'h0000;
		else begin
			case (reg_addr)
				`REG_TRI_HALF: reg_rdata_q <= tri_half_q;
				`REG_STATUS:   reg_rdata_q <= {10'h000, lock_fault_q,
				                               startup_q, state_q};
				`REG_DUTY:     reg_rdata_q <= {5'h00, applied_q};
				default:       reg_rdata_q <= 16'h0000;
			endcase
		end
	end

	// ****************************************************
	// pwm-mode command: duty from high time over period
	// ****************************************************
	reg  [15:0] per_cnt_q;   // cycles since last rising edge
	reg  [15:0] hi_cnt_q;    // high cycles in that span
	reg  [10:0] pwm_duty_q;  // measured duty, per-mille
	reg         vsp_d1_q;
	wire        vsp_rise = vsp_s & ~vsp_d1_q;
	wire [25:0] hi_scaled = hi_cnt_q * 10'h3e8;
	wire [25:0] pwm_ratio = hi_scaled / {10'h000, per_cnt_q};
	// a stuck input (0 % or 100 %) runs the period counter up to ffff, where it restarts
	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			vsp_d1_q   <= 1'b0;
			per_cnt_q  <= 16'h0000;
			hi_cnt_q   <= 16'h0000;
			pwm_duty_q <= 11'h000;
		end else begin
			vsp_d1_q <= vsp_s;
			if (vsp_rise) begin
				if (per_cnt_q != 16'h0000)
					pwm_duty_q <= pwm_ratio[10:0];
				per_cnt_q <= 16'h0001;
				hi_cnt_q  <= 16'h0001;
			end else if (per_cnt_q == 16'hffff) begin
				pwm_duty_q <= vsp_s ? `DUTY_FULL : 11'h000;
				per_cnt_q  <= 16'h0000;
				hi_cnt_q   <= 16'h0000;
			end else begin
				per_cnt_q <= per_cnt_q + 16'h0001;
				if (vsp_s)
					hi_cnt_q <= hi_cnt_q + 16'h0001;
			end
		end
	end

	// ****************************************************
	// dc-mode command: level to equivalent duty
	// ****************************************************
	reg  [12:0] mv_clip;     // command held inside 1 V .. 4 V
	reg  [10:0] dc_duty;
	reg  [10:0] equiv_duty;  // duty of whichever mode is active
	reg  [10:0] lin_duty;    // working range spread to full scale
	localparam [19:0] DC_OFFS_C = `DC_OFFS_MV;  // held at datapath width
	localparam [19:0] DC_DIV_C  = `DC_DIV;
	wire [19:0] dc_prod = mv_clip * 7'h61;
	wire [19:0] dc_num  = dc_prod - DC_OFFS_C;
	wire [19:0] dc_quo  = dc_num / DC_DIV_C;
	wire [21:0] lin_num = (equiv_duty - `WORK_LO) * 11'h3e8;
	wire [21:0] lin_quo = lin_num / (`WORK_HI - `WORK_LO);
	// slope 97 is folded into the literal 7'h61 above
	always @* begin
		if (speed_command_level_mv < `DC_MIN_MV)
			mv_clip = `DC_MIN_MV;
		else if (speed_command_level_mv > `DC_MAX_MV)
			mv_clip = `DC_MAX_MV;
		else
			mv_clip = speed_command_level_mv;
		dc_duty    = dc_quo[10:0];
		equiv_duty = pwm_mode ? pwm_duty_q : dc_duty;
		if (equiv_duty <= `WORK_LO)
			lin_duty = 11'h000;
		else if (equiv_duty >= `WORK_HI)
			lin_duty = `DUTY_FULL;
		else
			lin_duty = lin_quo[10:0];
	end
	// register the target so the dividers are off the drive path
	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n)
			target_q <= 11'h000;
		else
			target_q <= lin_duty;
	end

	// ****************************************************
	// ramps: pwm carrier and slow soft-start ramp
	// ****************************************************
	wire [15:0]      tri_val;
	wire [SST_W-1:0] sst_val;
	wire             sst_end;
	tri_ramp #(.W(16)) u_pwm_ramp (
		.ref_clk      (ref_clk),
		.arst_n       (arst_n),
		.half_count   (tri_half_q),
		.ramp_q       (tri_val),
		.period_end_q ()
	);
	tri_ramp #(.W(SST_W)) u_sst_ramp (
		.ref_clk      (ref_clk),
		.arst_n       (arst_n),
		.half_count   (SST_HALF_C),
		.ramp_q       (sst_val),
		.period_end_q (sst_end)
	);

	// ****************************************************
	// hall comparator
	// ****************************************************
	wire hall_lvl;
	wire hall_edge;
	hall_hysteresis u_hall (
		.ref_clk      (ref_clk),
		.arst_n       (arst_n),
		.hall_plus    (hall_plus),
		.hall_minus   (hall_minus),
		.hall_level_q (hall_lvl),
		.hall_edge_q  (hall_edge)
	);

	// ****************************************************
	// start-up, soft start and lock state machine
	// ****************************************************
	reg  [LOCK_W-1:0] lock_cnt_q;  // cycles since the last hall edge
	reg               sleep_d1_q;
	wire ss_done  = (applied_q >= target_q) && (applied_q != 11'h000);
	wire lock_hit = (lock_cnt_q == LOCK_C);
	// startup is entered after reset and again after sleep ends
	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_q    <= ST_START;
			applied_q  <= 11'h000;
			lock_cnt_q <= {LOCK_W{1'b0}};
			sleep_d1_q <= 1'b0;
		end else begin
			sleep_d1_q <= sleep_s;
			if (hall_edge || !(state_q[1] || state_q[2]))
				lock_cnt_q <= {LOCK_W{1'b0}};
			else if (!lock_hit)
				lock_cnt_q <= lock_cnt_q + {{(LOCK_W-1){1'b0}}, 1'b1};
			case (state_q)
				ST_START: begin
					// bypass tied pin gives the full command at once
					if (ss_bypass)
						applied_q <= target_q;
					else if (sst_end && !ss_done)
						applied_q <= (target_q - applied_q < STEP_C)
						             ? target_q
						             : applied_q + STEP_C;
					if (sleep_s)
						state_q <= ST_SLEEP;
					else if (lock_hit)
						state_q <= ST_LOCK;
					else if (ss_done && hall_edge)
						state_q <= ST_RUN;
				end
				ST_RUN: begin
					applied_q <= target_q;
					if (sleep_s)
						state_q <= ST_SLEEP;
					else if (lock_hit)
						state_q <= ST_LOCK;
				end
				ST_LOCK: begin
					applied_q <= 11'h000;
					if (sleep_s)
						state_q <= ST_SLEEP;
				end
				ST_SLEEP: begin
					applied_q <= 11'h000;
					if (!sleep_s && sleep_d1_q)
						state_q <= ST_START;
				end
				default: state_q <= ST_START;
			endcase
		end
	end

	// ****************************************************
	// drive pwm: duty against the carrier ramp
	// ****************************************************
	wire [26:0] ramp_side = tri_val * 11'h3e8;
	wire [26:0] duty_side = applied_q * tri_half_q;
	// carrier period is twice the turning point plus two cycles, whichever mode
	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			drive_pwm_q  <= 1'b0;
			lock_fault_q <= 1'b0;
			startup_q    <= 1'b1;
		end else begin
			drive_pwm_q  <= (ramp_side < duty_side);
			lock_fault_q <= state_q[3];
			startup_q    <= state_q[1];
		end
	end

	// ****************************************************
	// speed pulse: toggle every n hall edges
	// ****************************************************
	reg [1:0] edge_cnt_q;
	reg [1:0] div_last;
	always @* begin
		case (fg_sel)
			`FG_DIV2: div_last = 2'h1;
			`FG_DIV3: div_last = 2'h2;
			default:  div_last = 2'h0;
		endcase
	end
	// n hall cycles hold 2n edges, and one pulse cycle two toggles
	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			edge_cnt_q        <= 2'h0;
			speed_pulse_out_q <= 1'b0;
		end else if (!state_q[2]) begin
			edge_cnt_q        <= 2'h0;
			speed_pulse_out_q <= 1'b0;
		end else if (hall_edge) begin
			if (edge_cnt_q >= div_last) begin
				edge_cnt_q        <= 2'h0;
				speed_pulse_out_q <= ~speed_pulse_out_q;
			end else
				edge_cnt_q <= edge_cnt_q + 2'h1;
		end
	end

	// ****************************************************
	// drive phase: lag from hall edge to conduction mark
	// ****************************************************
	reg  [15:0] lag_cnt_q;   // cycles since the last hall edge
	reg  [15:0] lag_seen_q;  // lag captured at conduction mark
	reg         cond_d1_q;
	wire        cond_rise = cond_s & ~cond_d1_q;
	// a single step per edge keeps the correction from hunting
	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			lag_cnt_q       <= 16'h0000;
			lag_seen_q      <= 16'h0000;
			cond_d1_q       <= 1'b0;
			phase_advance_q <= 16'h0000;
		end else begin
			cond_d1_q <= cond_s;
			if (hall_edge)
				lag_cnt_q <= 16'h0000;
			else if (lag_cnt_q != 16'hffff)
				lag_cnt_q <= lag_cnt_q + 16'h0001;
			if (cond_rise)
				lag_seen_q <= lag_cnt_q;
			if (ps_fixed)
				phase_advance_q <= 16'h0000;
			else if (hall_edge) begin
				if (lag_seen_q > phase_advance_q)
					phase_advance_q <= phase_advance_q + 16'h0001;
				else if (lag_seen_q < phase_advance_q)
					phase_advance_q <= phase_advance_q - 16'h0001;
			end
		end
	end

endmodule // fan_speed_ctrl

// ---- verif/fan_speed_ctrl_asserts.sv ----
// port assertions for the fan speed and hall control block
`timescale 1ns/1ps

module fan_speed_ctrl_asserts #(
	parameter LOCK_CYCLES = 50000000
) (
	// clock and reset
	input wire        ref_clk,
	input wire        arst_n,
	// watched inputs
	input wire [12:0] speed_command_level_mv,
	input wire        tri_cap_tied_ref,
	input wire [11:0] hall_plus,
	input wire        phase_shift_select,
	input wire        sleep_req,
	input wire [3:0]  reg_addr,
	input wire        reg_rd,
	// watched outputs
	input wire [15:0] reg_rdata_q,
	input wire        drive_pwm_q,
	input wire        speed_pulse_out_q,
	input wire [15:0] phase_advance_q,
	input wire        lock_fault_q,
	input wire        startup_q
);
	// ****************************************************
	// helper counters
	// ****************************************************
	reg [31:0] quiet_q; // cycles since the hall samples last moved
	reg [7:0]  low_q;   // cycles of a settled zero dc command in run
	// low_q saturates; quiet_q restarts on hall movement and only wraps if the hall never moves
	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			quiet_q <= 32'h0;
			low_q <= 8'h0;
		end else begin
			quiet_q <= $changed(hall_plus) ? 32'h0 : quiet_q + 32'h1;
			if (tri_cap_tied_ref || speed_command_level_mv > 13'h3e8 ||
			    startup_q || lock_fault_q || sleep_req)
				low_q <= 8'h0;
			else if (low_q != 8'hff)
				low_q <= low_q + 8'h1;
		end
	end

	// ****************************************************
	// assertions
	// ****************************************************
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!arst_n);
	// sleep pin held low long enough to pass its synchroniser
	sequence sleep_quiet;
		(!sleep_req) [*4];
	endsequence
	// fixed phase selected long enough to pass its synchroniser
	sequence fixed_held;
		phase_shift_select [*4];
	endsequence

	chk_rdata_idle: assert property (
		!$past(reg_rd) |-> reg_rdata_q == 16'h0)
		else $error("read data not zero outside its slot");
	chk_status_flags: assert property (
		reg_rd && reg_addr == 4'h1 |=> $onehot(reg_rdata_q[3:0]) &&
		reg_rdata_q[5:4] == $past({lock_fault_q, startup_q}))
		else $error("status word disagrees with flags");
	chk_pulse_startup: assert property (
		startup_q |-> !speed_pulse_out_q)
		else $error("speed pulse during start-up");
	chk_pulse_lock: assert property (
		lock_fault_q && $past(lock_fault_q) |-> !speed_pulse_out_q)
		else $error("speed pulse while locked");
	chk_fixed_phase: assert property (
		fixed_held |=> phase_advance_q == 16'h0)
		else $error("phase advance not zero in fixed mode");
	chk_lock_latched: assert property (
		sleep_quiet ##0 lock_fault_q |=> lock_fault_q)
		else $error("lock released without sleep");
	chk_lock_wait: assert property (
		$rose(lock_fault_q) |-> quiet_q >= LOCK_CYCLES - 4)
		else $error("lock raised before the hall timeout");
	chk_zero_cmd: assert property (
		low_q > 8'h10 |-> !drive_pwm_q)
		else $error("drive pulses with a stop-level command");
endmodule // fan_speed_ctrl_asserts

bind fan_speed_ctrl fan_speed_ctrl_asserts #(
	.LOCK_CYCLES(LOCK_CYCLES)
) fan_speed_ctrl_asserts_i (
	.ref_clk(ref_clk),
	.arst_n(arst_n),
	.speed_command_level_mv(speed_command_level_mv),
	.tri_cap_tied_ref(tri_cap_tied_ref),
	.hall_plus(hall_plus),
	.phase_shift_select(phase_shift_select),
	.sleep_req(sleep_req),
	.reg_addr(reg_addr),
	.reg_rd(reg_rd),
	.reg_rdata_q(reg_rdata_q),
	.drive_pwm_q(drive_pwm_q),
	.speed_pulse_out_q(speed_pulse_out_q),
	.phase_advance_q(phase_advance_q),
	.lock_fault_q(lock_fault_q),
	.startup_q(startup_q)
);

// ---- verif/fan_host_model.sv ----
// host side model: speed command pwm, hall pair and conduction mark
`timescale 1ns/1ps

module fan_host_model (
	// clock and reset
	input  wire        ref_clk,
	input  wire        arst_n,
	// settings from the bench
	input  wire [15:0] pwm_high,
	input  wire [15:0] pwm_period,
	input  wire [15:0] hall_half,
	input  wire [15:0] lag,
	input  wire        hall_run,
	input  wire        ss_bypass,
	// pins toward the block
	output reg         speed_command_input,
	output reg  [11:0] hall_plus,
	output wire [11:0] hall_minus,
	output reg         conduction_ref,
	output wire        soft_start_ramp_cap_tied
);
	reg [15:0] pwm_q;   // position in the command period
	reg [15:0] hall_q;  // cycles since the last hall flip
	reg        level_q; // magnet polarity under the sensor
	reg [15:0] lag_q;   // countdown to the conduction mark
	// pin tied to the reference when soft start is unwanted
	assign soft_start_ramp_cap_tied = ss_bypass;
	// minus side sits mid-rail; plus swings 40 mV either side of it, well past hysteresis
	assign hall_minus = 12'h9c4;
	// command pwm, hall flips and a lagging conduction mark
	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			pwm_q <= 16'h0;
			hall_q <= 16'h0;
			level_q <= 1'b0;
			lag_q <= 16'h0;
			speed_command_input <= 1'b0;
			hall_plus <= 12'h99c;
			conduction_ref <= 1'b0;
		end else begin
			pwm_q <= (pwm_q + 16'h1 >= pwm_period) ? 16'h0 : pwm_q + 16'h1;
			speed_command_input <= (pwm_q < pwm_high);
			if (hall_run && hall_q + 16'h1 >= hall_half) begin
				hall_q <= 16'h0;
				level_q <= !level_q;
				hall_plus <= level_q ? 12'h99c : 12'h9ec;
				lag_q <= lag;
			end else begin
				hall_q <= hall_run ? hall_q + 16'h1 : hall_q;
				lag_q <= (lag_q != 16'h0) ? lag_q - 16'h1 : 16'h0;
			end
			// the mark follows the magnet a fixed lag later
			if (lag_q == 16'h1)
				conduction_ref <= level_q;
		end
	end
endmodule // fan_host_model

// ---- verif/fan_speed_ctrl_bench.sv ----
// self-checking bench for the fan speed and hall control block
`timescale 1ns/1ps

module fan_speed_ctrl_bench;
	// ****************************************************
	// signals
	// ****************************************************
	reg         ref_clk, arst_n, tri_cap_tied_ref, phase_shift_select;
	reg         sleep_req, reg_wr, reg_rd, hall_run, ss_bypass;
	reg  [12:0] speed_command_level_mv;
	reg  [1:0]  pulse_divide_select;
	reg  [3:0]  reg_addr;
	reg  [15:0] reg_wdata, pwm_high, lag_set;
	wire        speed_command_input, conduction_ref, ss_tied;
	wire [11:0] hall_plus, hall_minus;
	wire [15:0] reg_rdata_q, phase_advance_q;
	wire        drive_pwm_q, speed_pulse_out_q, lock_fault_q, startup_q;
	logic [15:0] rd;                            // last read word
	int         errors, tests_run, fg_tog, hi_cnt, rises, i;
	int         mvs[5] = '{1000, 1500, 2730, 4500, 2000};

	// short counts keep soft start and lock within a brief run
	fan_speed_ctrl #(.SST_HALF(20), .LOCK_CYCLES(2000), .SS_STEP(100))
	fan_speed_ctrl_i (.ref_clk(ref_clk), .arst_n(arst_n),
		.speed_command_input(speed_command_input),
		.speed_command_level_mv(speed_command_level_mv),
		.tri_cap_tied_ref(tri_cap_tied_ref),
		.soft_start_ramp_cap_tied(ss_tied),
		.hall_plus(hall_plus), .hall_minus(hall_minus),
		.pulse_divide_select(pulse_divide_select),
		.phase_shift_select(phase_shift_select),
		.conduction_ref(conduction_ref), .sleep_req(sleep_req),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
		.drive_pwm_q(drive_pwm_q), .speed_pulse_out_q(speed_pulse_out_q),
		.phase_advance_q(phase_advance_q), .lock_fault_q(lock_fault_q),
		.startup_q(startup_q));
	fan_host_model fan_host_model_i (.ref_clk(ref_clk), .arst_n(arst_n),
		.pwm_high(pwm_high), .pwm_period(16'h0064), .hall_half(16'h0032),
		.lag(lag_set), .hall_run(hall_run), .ss_bypass(ss_bypass),
		.speed_command_input(speed_command_input), .hall_plus(hall_plus),
		.hall_minus(hall_minus), .conduction_ref(conduction_ref),
		.soft_start_ramp_cap_tied(ss_tied));

	// ****************************************************
	// tasks
	// ****************************************************
	task check(input string what, input logic [15:0] seen, exp);
		tests_run++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask
	task finish_test;
		$display("checks %0d, errors %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task reg_write(input logic [3:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask
	// data stands only in the cycle after the strobe
	task reg_read(input logic [3:0] a, output logic [15:0] d);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata_q;
	endtask
	// count pulse toggles, drive-high cycles and drive rises
	task watch(input int n);
		logic fg_last, pwm_last;
		fg_tog = 0;
		hi_cnt = 0;
		rises = 0;
		fg_last = speed_pulse_out_q;
		pwm_last = drive_pwm_q;
		repeat (n) begin
			@(posedge ref_clk);
			#1;
			fg_tog += (speed_pulse_out_q !== fg_last);
			rises += (drive_pwm_q && !pwm_last);
			hi_cnt += drive_pwm_q;
			fg_last = speed_pulse_out_q;
			pwm_last = drive_pwm_q;
		end
	endtask
	// applied duty per-mille for a dc command in millivolts
	function automatic [15:0] dc_duty(input int mv);
		int v, d;
		v = mv < 1000 ? 1000 : (mv > 4000 ? 4000 : mv);
		d = (97 * v - 88000) / 300;
		if (d <= 30)
			dc_duty = 16'h0;
		else if (d >= 580)
			dc_duty = 16'h3e8;
		else
			dc_duty = 16'((d - 30) * 1000 / 550);
	endfunction

	// ****************************************************
	// clock, watchdog and test sequence
	// ****************************************************
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = !ref_clk;
	end
	// the sequence needs about 20000 cycles
	initial begin
		repeat (40000) @(posedge ref_clk);
		errors++;
		$display("unexpected timeout: expected end of tests, seen hang");
		finish_test;
	end
	initial begin
		arst_n = 0; tri_cap_tied_ref = 1; phase_shift_select = 1;
		sleep_req = 0; reg_wr = 0; reg_rd = 0; hall_run = 1; ss_bypass = 0;
		speed_command_level_mv = 13'h7d0; pulse_divide_select = 2'h0;
		reg_addr = 4'h0; reg_wdata = 16'h0; pwm_high = 16'h001e;
		lag_set = 16'h000c;
		repeat (10) @(posedge ref_clk);
		arst_n <= 1'b1;
		reg_read(4'h0, rd); check("tri half reset", rd, 16'h039d);
		reg_write(4'h0, 16'h0031);
		reg_read(4'h0, rd); check("tri half", rd, 16'h0031);
		reg_write(4'h1, 16'hffff);
		reg_write(4'h2, 16'hffff);
		reg_read(4'h1, rd); check("status start", rd, 16'h0012);
		reg_read(4'h7, rd); check("unmapped read", rd, 16'h0000);
		watch(150); check("start pulses", 16'(fg_tog), 16'h0);
		check("soft start busy", {15'h0, startup_q}, 16'h1);
		watch(600); check("soft start done", {15'h0, startup_q}, 16'h0);
		reg_read(4'h2, rd); check("pwm duty", rd, 16'h01ea);
		check("fixed phase", phase_advance_q, 16'h0);
		for (i = 0; i < 3; i++) begin
			pulse_divide_select <= 2'(i);
			watch(200);
			watch(3000);
			check("pulse toggles", {15'h0, fg_tog >= 60 / (i + 1) - 1 &&
				fg_tog <= 60 / (i + 1) + 1}, 16'h1);
		end
		phase_shift_select <= 1'b0;
		repeat (2) begin
			watch(2000); // advance settles on the mark's lag
			check("auto phase", {15'h0, phase_advance_q + 16'h1 >= lag_set &&
				phase_advance_q <= lag_set + 16'h1}, 16'h1);
			lag_set <= 16'h0014;
		end
		phase_shift_select <= 1'b1;
		watch(10); check("phase zeroed", phase_advance_q, 16'h0);
		tri_cap_tied_ref <= 1'b0;
		foreach (mvs[k]) begin
			speed_command_level_mv <= 13'(mvs[k]);
			watch(300);
			reg_read(4'h2, rd); check("dc duty", rd, dc_duty(mvs[k]));
		end
		watch(1000);
		check("carrier", {15'h0, rises >= 9 && rises <= 11}, 16'h1);
		check("dc high", {15'h0, hi_cnt >= 567 && hi_cnt <= 607}, 16'h1);
		hall_run <= 1'b0;
		watch(2100); check("lock", {15'h0, lock_fault_q}, 16'h1);
		reg_read(4'h1, rd); check("status lock", rd, 16'h0028);
		hall_run <= 1'b1;
		ss_bypass <= 1'b1;
		watch(200); check("lock held", {15'h0, lock_fault_q}, 16'h1);
		sleep_req <= 1'b1;
		watch(10);
		reg_read(4'h1, rd); check("status sleep", rd, 16'h0001);
		sleep_req <= 1'b0;
		watch(5); check("restart", {15'h0, startup_q}, 16'h1);
		watch(300); check("bypass start", {15'h0, startup_q}, 16'h0);
		reg_read(4'h2, rd); check("bypass duty", rd, dc_duty(2000));
		finish_test;
	end
endmodule // fan_speed_ctrl_bench
